// [mpc_counter.sv]
// multi mode pulse counter: four fast inputs, accumulators, compare outputs, AXI4-Lite slave
// assumes pins asynchronous to core_clk, pwm_drive from a same-clock generator
//
// Behaviour
// - four inputs, each freq/total/pulse mode; quad on inputs one and three only
// - each accumulator readable as a register
// - edges timed at 1 us resolution
// - frequency in hertz, four window widths
// - totalize counts chosen edge by one
// - nonzero rev count wraps totalizer to zero
// - clear bits hold totalizers at zero
// - inputs three/four reset totalizers one/two
// - hardware reset on chosen edge, fast
// - compare drives output when totalizer reaches threshold
// - outputs select digital, pwm or compare
// - threshold writable; zero forces output low
// - high-width mode counts high microseconds
// - low-width mode counts low microseconds
// - period modes from rising or falling edge
// - pulse accumulator holds latest completed measurement
// - quad pairs inputs one-two and three-four
// - direction bit picks up or down
// - quad counts all four phase transitions
// - quad wraps at rev count both ways
// - control bits clear or preset quad counters
// - marker loads zero or rev-1 by direction
// - async marker zeroes on chosen edge
//
// Our own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
module mpc_counter
	import mpc_pkg::*;
#(
	parameter int unsigned FREQ_WIN0_US = 1000000, // sample window choice 0
	parameter int unsigned FREQ_WIN1_US = 100000,  // sample window choice 1
	parameter int unsigned FREQ_WIN2_US = 10000,   // sample window choice 2
	parameter int unsigned FREQ_WIN3_US = 1000     // sample window choice 3
) (
	input  wire logic                     core_clk,           // 10 MHz clock
	input  wire logic                     sys_rst,            // async reset, high
	input  wire logic [mpc_pkg::NUM_CH-1:0] fast_input_counter, // counter pins
	input  wire logic [1:0]               pwm_drive,          // pwm generator levels
	output logic                          special_output_one, // output one
	output logic                          special_output_two, // output two
	input  wire logic [7:0]               s_axi_awaddr,       // write address
	input  wire logic                     s_axi_awvalid,      // write address valid
	output logic                          s_axi_awready,      // write address ready
	input  wire logic [31:0]              s_axi_wdata,        // write data
	input  wire logic [3:0]               s_axi_wstrb,        // byte enables
	input  wire logic                     s_axi_wvalid,       // write data valid
	output logic                          s_axi_wready,       // write data ready
	output logic [1:0]                    s_axi_bresp,        // write response
	output logic                          s_axi_bvalid,       // write response valid
	input  wire logic                     s_axi_bready,       // write response ready
	input  wire logic [7:0]               s_axi_araddr,       // read address
	input  wire logic                     s_axi_arvalid,      // read address valid
	output logic                          s_axi_arready,      // read address ready
	output logic [31:0]                   s_axi_rdata,        // read data
	output logic [1:0]                    s_axi_rresp,        // read response
	output logic                          s_axi_rvalid,       // read data valid
	input  wire logic                     s_axi_rready        // read data ready
);
	import mpc_pkg::*;

	localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);

	logic [7:0]       tick_cnt_r;
	logic             tick;
	logic [3:0]       lvl;
	logic [3:0]       rise;
	logic [3:0]       fall;
	logic [CFG_W-1:0] cfg_r [NUM_CH];
	logic [31:0]      rev_r [NUM_CH];
	logic [31:0]      thr_r [2];
	logic [CTL_W-1:0] ctl_r;
	logic [31:0]      acc_r [NUM_CH];
	logic [31:0]      cnt_r [NUM_CH];
	logic [31:0]      win_r [NUM_CH];
	logic [3:0]       last_up_r;
	logic [1:0]       cmp_r;
	logic [2:0]       mode      [NUM_CH];
	logic [31:0]      win_len   [NUM_CH];
	logic [3:0]       cnt_edge;
	logic [3:0]       hw_clr;
	logic [3:0]       q_up;
	logic [3:0]       q_dn;
	logic [3:0]       mark_hit;
	logic [3:0]       p_start;
	logic [3:0]       p_end;

	// 1 us pacing tick
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			tick_cnt_r <= 8'h00;
		end else if (tick_cnt_r == TICK_LAST) begin
			tick_cnt_r <= 8'h00;
		end else begin
			tick_cnt_r <= tick_cnt_r + 8'h01;
		end
	end
	assign tick = (tick_cnt_r == TICK_LAST);

	mpc_in_cond #(
		.N (NUM_CH)
	) u_cond (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.tick     (tick),
		.pin_in   (fast_input_counter),
		.lvl      (lvl),
		.rise     (rise),
		.fall     (fall)
	);

	function automatic logic [31:0] wrap_inc(input logic [31:0] v, input logic [31:0] rev);
		return (rev != 32'h0000_0000 && v == rev - 32'h0000_0001) ? 32'h0000_0000
			: v + 32'h0000_0001;
	endfunction

	function automatic logic [31:0] wrap_dec(input logic [31:0] v, input logic [31:0] rev);
		return (rev != 32'h0000_0000 && v == 32'h0000_0000) ? rev - 32'h0000_0001
			: v - 32'h0000_0001;
	endfunction

	// per-channel event decode
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			logic       a_r;
			logic       a_f;
			logic       b_r;
			logic       b_f;
			logic       a_l;
			logic       b_l;
			logic       fwd;
			logic       bwd;
			logic [1:0] sub;
			int unsigned b;
			int unsigned p;
			b = (i + 1) % NUM_CH;
			p = (i + 2) % NUM_CH;
			mode[i] = cfg_r[i][CFG_MODE_LSB +: 3];
			sub = cfg_r[i][CFG_SUB_LSB +: 2];
			unique case (sub)
				2'h0: win_len[i] = FREQ_WIN0_US;
				2'h1: win_len[i] = FREQ_WIN1_US;
				2'h2: win_len[i] = FREQ_WIN2_US;
				2'h3: win_len[i] = FREQ_WIN3_US;
			endcase
			// edge bit set selects falling; positive logic assumed at the pin
			cnt_edge[i] = cfg_r[i][CFG_EDGE_BIT] ? fall[i] : rise[i];
			// reset input only honoured once the target totalizer is set up
			hw_clr[i] = (i < 2) && mode[i] == MODE_TOTAL && mode[p] == MODE_TOTRST
				&& (cfg_r[p][CFG_EDGE_BIT] ? fall[p] : rise[p]);
			a_r = rise[i];
			a_f = fall[i];
			b_r = rise[b];
			b_f = fall[b];
			a_l = lvl[i];
			b_l = lvl[b];
			fwd = (a_r & ~b_l) | (b_r & a_l) | (a_f & b_l) | (b_f & ~a_l);
			bwd = (a_r & b_l) | (b_r & ~a_l) | (a_f & ~b_l) | (b_f & a_l);
			q_up[i] = cfg_r[i][CFG_QDIR_BIT] ? bwd : fwd;
			q_dn[i] = cfg_r[i][CFG_QDIR_BIT] ? fwd : bwd;
			unique case (cfg_r[p][CFG_MARK_LSB +: 2])
				MARK_RISE: mark_hit[i] = rise[p];
				MARK_FALL: mark_hit[i] = fall[p];
				MARK_BOTH: mark_hit[i] = rise[p] | fall[p];
				MARK_DIR:  mark_hit[i] = rise[p];
			endcase
			mark_hit[i] = mark_hit[i] && i == 0 && mode[p] == MODE_MARKER;
			unique case (sub)
				SUB_HIGH: begin
					p_start[i] = rise[i];
					p_end[i]   = fall[i];
				end
				SUB_LOW: begin
					p_start[i] = fall[i];
					p_end[i]   = rise[i];
				end
				SUB_PER_RISE: begin
					p_start[i] = rise[i];
					p_end[i]   = rise[i];
				end
				SUB_PER_FALL: begin
					p_start[i] = fall[i];
					p_end[i]   = fall[i];
				end
			endcase
		end
	end

	// accumulators, one engine per input
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < NUM_CH; i++) begin
				acc_r[i] <= 32'h0000_0000;
				cnt_r[i] <= 32'h0000_0000;
				win_r[i] <= 32'h0000_0000;
			end
			last_up_r <= 4'hF;
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				case (mode[i])
					MODE_FREQ: begin
						if (tick && win_r[i] >= win_len[i] - 32'h0000_0001) begin
							acc_r[i] <= 32'(cnt_r[i] * (TICKS_PER_SEC / win_len[i]));
							cnt_r[i] <= {31'h0000_0000, rise[i]};
							win_r[i] <= 32'h0000_0000;
						end else if (tick) begin
							win_r[i] <= win_r[i] + 32'h0000_0001;
							cnt_r[i] <= cnt_r[i] + {31'h0000_0000, rise[i]};
						end
					end
					MODE_TOTAL: begin
						if (ctl_r[CTL_CLR_LSB + i]) begin
							acc_r[i] <= 32'h0000_0000;
						end else if (hw_clr[i]) begin
							acc_r[i] <= 32'h0000_0000;
						end else if (cnt_edge[i]) begin
							acc_r[i] <= wrap_inc(acc_r[i], rev_r[i]);
						end
					end
					MODE_PULSE: begin
						if (tick) begin
							if (p_end[i]) begin
								acc_r[i] <= cnt_r[i] + 32'h0000_0001;
							end
							if (p_start[i]) begin
								cnt_r[i] <= 32'h0000_0000;
							end else begin
								cnt_r[i] <= cnt_r[i] + 32'h0000_0001;
							end
						end
					end
					MODE_QUAD: begin
						if (i == 0 || i == 2) begin
							if (ctl_r[CTL_CLR_LSB + i]) begin
								acc_r[i] <= 32'h0000_0000;
							end else if ((i == 0 && ctl_r[CTL_SET1_BIT])
								|| (i == 2 && ctl_r[CTL_SET3_BIT])) begin
								acc_r[i] <= rev_r[i] - 32'h0000_0001;
							end else if (mark_hit[i]) begin
								if (cfg_r[2][CFG_MARK_LSB +: 2] == MARK_DIR && !last_up_r[i]) begin
									acc_r[i] <= rev_r[i] - 32'h0000_0001;
								end else begin
									acc_r[i] <= 32'h0000_0000;
								end
							end else if (q_up[i]) begin
								acc_r[i] <= wrap_inc(acc_r[i], rev_r[i]);
								last_up_r[i] <= 1'b1;
							end else if (q_dn[i]) begin
								acc_r[i] <= wrap_dec(acc_r[i], rev_r[i]);
								last_up_r[i] <= 1'b0;
							end
						end
					end
					default: begin
						acc_r[i] <= 32'h0000_0000;
						cnt_r[i] <= 32'h0000_0000;
						win_r[i] <= 32'h0000_0000;
					end
				endcase
			end
		end
	end

	// compare and output steering
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cmp_r <= 2'h0;
		end else begin
			for (int k = 0; k < 2; k++) begin
				cmp_r[k] <= thr_r[k] != 32'h0000_0000 && mode[k] == MODE_TOTAL
					&& acc_r[k] >= thr_r[k];
			end
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			special_output_one <= 1'b0;
			special_output_two <= 1'b0;
		end else begin
			unique case (ctl_r[CTL_OSEL1_LSB +: 2])
				OSEL_DIGITAL: special_output_one <= ctl_r[CTL_DOUT1_BIT];
				OSEL_PWM:     special_output_one <= pwm_drive[0];
				OSEL_CMP:     special_output_one <= cmp_r[0];
				default:      special_output_one <= 1'b0;
			endcase
			unique case (ctl_r[CTL_OSEL2_LSB +: 2])
				OSEL_DIGITAL: special_output_two <= ctl_r[CTL_DOUT2_BIT];
				OSEL_PWM:     special_output_two <= pwm_drive[1];
				OSEL_CMP:     special_output_two <= cmp_r[1];
				default:      special_output_two <= 1'b0;
			endcase
		end
	end

	// AXI4-Lite slave; address and data may arrive in either order
	logic        aw_full_r;
	logic        w_full_r;
	logic [7:0]  awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0]  wstrb_r;
	logic        wr_go;
	logic        wr_hit;
	logic        rd_hit;
	logic [31:0] rd_val;

	assign s_axi_awready = !aw_full_r && !s_axi_bvalid;
	assign s_axi_wready  = !w_full_r && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_go         = aw_full_r && w_full_r && !s_axi_bvalid;
	assign wr_hit        = awaddr_r <= OFS_REV_BASE + 8'h0C || awaddr_r == OFS_THR_ONE
		|| awaddr_r == OFS_THR_TWO || awaddr_r == OFS_CTRL;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int j = 0; j < 4; j++) begin
			if (s[j]) begin
				r[j*8 +: 8] = d[j*8 +: 8];
			end
		end
		return r;
	endfunction

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			aw_full_r    <= 1'b0;
			w_full_r     <= 1'b0;
			awaddr_r     <= 8'h00;
			wdata_r      <= 32'h0000_0000;
			wstrb_r      <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_r <= 1'b1;
				awaddr_r  <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_r <= 1'b1;
				wdata_r  <= s_axi_wdata;
				wstrb_r  <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_full_r    <= 1'b0;
				w_full_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < NUM_CH; i++) begin
				cfg_r[i] <= CFG_RST;
				rev_r[i] <= REV_RST;
			end
			thr_r[0] <= THR_RST;
			thr_r[1] <= THR_RST;
			ctl_r    <= CTRL_RST;
		end else if (wr_go) begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (awaddr_r == OFS_CFG_BASE + 8'(4 * i)) begin
					cfg_r[i] <= CFG_W'(merge({23'h00_0000, cfg_r[i]}, wdata_r, wstrb_r));
				end
				if (awaddr_r == OFS_REV_BASE + 8'(4 * i)) begin
					rev_r[i] <= merge(rev_r[i], wdata_r, wstrb_r);
				end
			end
			if (awaddr_r == OFS_THR_ONE) begin
				thr_r[0] <= merge(thr_r[0], wdata_r, wstrb_r);
			end
			if (awaddr_r == OFS_THR_TWO) begin
				thr_r[1] <= merge(thr_r[1], wdata_r, wstrb_r);
			end
			if (awaddr_r == OFS_CTRL) begin
				ctl_r <= CTL_W'(merge({20'h0_0000, ctl_r}, wdata_r, wstrb_r));
			end
		end
	end

	always_comb begin
		rd_val = 32'h0000_0000;
		rd_hit = 1'b1;
		unique case ({s_axi_araddr[7:2], 2'b00})
			8'h00, 8'h04, 8'h08, 8'h0C:
				rd_val = {23'h00_0000, cfg_r[s_axi_araddr[3:2]]};
			8'h10, 8'h14, 8'h18, 8'h1C:
				rd_val = rev_r[s_axi_araddr[3:2]];
			8'h20, 8'h24, 8'h28, 8'h2C:
				rd_val = acc_r[s_axi_araddr[3:2]];
			OFS_THR_ONE: rd_val = thr_r[0];
			OFS_THR_TWO: rd_val = thr_r[1];
			OFS_CTRL:    rd_val = {20'h0_0000, ctl_r};
			OFS_STAT:    rd_val = {26'h000_0000, cmp_r, lvl};
			default:     rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_val;
			s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// [mpc_counter_properties.sv]
// bus handshake assertions for mpc_counter, bound onto its ports
// assumes one clock domain and the package register map
`timescale 1ns/100ps
module mpc_checker
	import mpc_pkg::*;
(
	input wire logic        core_clk,      // clock
	input wire logic        sys_rst,       // reset, high
	input wire logic [7:0]  s_axi_araddr,  // read address
	input wire logic        s_axi_arvalid, // read address valid
	input wire logic        s_axi_arready, // read address ready
	input wire logic [31:0] s_axi_rdata,   // read data
	input wire logic [1:0]  s_axi_rresp,   // read response
	input wire logic        s_axi_rvalid,  // read valid
	input wire logic        s_axi_rready,  // read ready
	input wire logic        s_axi_awvalid, // write address valid
	input wire logic        s_axi_awready, // write address ready
	input wire logic        s_axi_wvalid,  // write data valid
	input wire logic        s_axi_wready,  // write data ready
	input wire logic [1:0]  s_axi_bresp,   // write response
	input wire logic        s_axi_bvalid,  // write response valid
	input wire logic        s_axi_bready   // write response ready
);
	import mpc_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer missing");
	a_rd_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read data dropped early");
	a_rd_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read valid stuck");
	a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	// both halves are parked one cycle before the write lands and bvalid rises
	a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer missing");
	a_wr_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_wr_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response stuck");
	a_wr_blocked: assert property (s_axi_bvalid |-> !(s_axi_awready || s_axi_wready))
		else $error("write taken while busy");
	a_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready &&
		s_axi_araddr > 8'h3F |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
		else $error("unmapped read not refused");
endmodule
bind mpc_counter mpc_checker mpc_checker_i (.*);

// [mpc_counter_tb.sv]
// self-checking bench for mpc_counter: bus master, pin source, queued read checks
// assumes the package register map and a 10 MHz clock
`timescale 1ns/100ps
module mpc_counter_tb;
	import mpc_pkg::*;
	logic        core_clk, sys_rst, out_one, out_two;
	logic [3:0]  pins, wstrb;
	logic [1:0]  pwm_drive, bresp, rresp, p;
	logic [7:0]  awaddr, araddr;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata;
	logic [33:0] exp_q[$];
	int          err_count, n_tests, n;
	int          wid [4] = '{120, 180, 300, 300};

	mpc_counter #(.FREQ_WIN0_US(400), .FREQ_WIN1_US(200), .FREQ_WIN2_US(400),
		.FREQ_WIN3_US(200)) mpc_counter_i (.core_clk(core_clk), .sys_rst(sys_rst),
		.fast_input_counter(pins), .pwm_drive(pwm_drive), .special_output_one(out_one),
		.special_output_two(out_two), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	mpc_pulse_src mpc_pulse_src_i (.pin(pins));

	task automatic check(input logic [33:0] got, input logic [33:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		if (err_count == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
		@(posedge core_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		check({32'h0000_0000, bresp}, {32'h0000_0000, r});
	endtask
	// expected value queued; the monitor below compares on the answer
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		exp_q.push_back(e);
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
	endtask
	// outputs lag a change by two cycles; four leaves margin
	task automatic outs(input logic [1:0] e);
		repeat (4) @(posedge core_clk);
		check({32'h0000_0000, out_two, out_one}, {32'h0000_0000, e});
	endtask

	always @(posedge core_clk)
		if (rvalid && rready) check({rresp, rdata}, exp_q.pop_front());

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	initial begin
		#11ms;
		err_count++;
		report_and_stop();
	end
	initial begin
		{sys_rst, awvalid, wvalid, bready, arvalid, rready} = 6'b10_0000;
		{awaddr, araddr, wdata, pwm_drive} = '0;
		wstrb = 4'hF;
		void'($urandom(32'h03a9));
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		for (int i = 0; i < 16; i++) rd(8'(i * 4), 34'h0);
		rd(8'h40, {RESP_SLVERR, 32'h0000_0000});
		wr(8'h44, 32'h0000_0001, RESP_SLVERR);
		n = $urandom_range(8, 6);
		wr(OFS_REV_BASE, 32'h0000_0005);
		wr(OFS_CTRL, 32'(OSEL_CMP) << CTL_OSEL1_LSB);
		wr(OFS_CFG_BASE, 32'(MODE_TOTAL));
		mpc_pulse_src_i.pulses(0, n, 100, 100);
		rd(OFS_ACC_BASE, 34'(n % 5));
		wr(OFS_THR_ONE, 32'(n % 5 + 1));
		outs(2'h0);
		wr(OFS_THR_ONE, 32'(n % 5));
		outs(2'h1);
		wr(OFS_THR_ONE, 32'h0000_0000);
		outs(2'h0);
		p = 2'($urandom);
		pwm_drive <= p;
		wr(OFS_CTRL, 32'h0000_0500);
		outs({p[1], 1'b1});
		p = 2'($urandom);
		pwm_drive <= p;
		wr(OFS_CTRL, 32'h0000_0840);
		outs({1'b1, p[0]});
		wr(OFS_CTRL, 32'h0000_0001);
		mpc_pulse_src_i.pulses(0, 2, 100, 100);
		rd(OFS_ACC_BASE, 34'h0);
		wr(OFS_CTRL, 32'h0000_0000);
		mpc_pulse_src_i.pulses(0, 2, 100, 100);
		rd(OFS_ACC_BASE, 34'h2);
		wr(OFS_CFG_BASE + 8'h08, 32'(MODE_TOTRST));
		mpc_pulse_src_i.pulses(2, 1, 100, 0);
		rd(OFS_ACC_BASE, 34'h0);
		for (int s = 0; s < 4; s++) begin
			wr(OFS_CFG_BASE, 32'(MODE_PULSE) | (32'(s) << CFG_SUB_LSB));
			mpc_pulse_src_i.pulses(0, 2, 120, 180);
			rd(OFS_ACC_BASE, 34'(wid[s]));
		end
		// every window spans whole periods, so each reads the same rate
		for (int s = 0; s < 4; s++) begin
			wr(OFS_CFG_BASE, 32'(MODE_FREQ) | (32'(s) << CFG_SUB_LSB));
			fork
				mpc_pulse_src_i.pulses(0, 5, 100, 100);
				begin
					#850us;
					rd(OFS_ACC_BASE, 34'h1388);
				end
			join
		end
		// off first: off mode zeroes the accumulator, dropping the last freq rate
		wr(OFS_CFG_BASE, 32'(MODE_OFF));
		wr(OFS_REV_BASE, 32'h0000_0003);
		wr(OFS_CFG_BASE, 32'(MODE_QUAD));
		mpc_pulse_src_i.steps(5, 1'b0);
		rd(OFS_ACC_BASE, 34'h2);
		mpc_pulse_src_i.steps(4, 1'b1);
		rd(OFS_ACC_BASE, 34'h1);
		wr(OFS_CTRL, 32'h0000_0010);
		rd(OFS_ACC_BASE, 34'h2);
		wr(OFS_CTRL, 32'h0000_0001);
		rd(OFS_ACC_BASE, 34'h0);
		wr(OFS_CFG_BASE, 32'(MODE_QUAD) | 32'h0000_0040);
		wr(OFS_CTRL, 32'h0000_0000);
		mpc_pulse_src_i.steps(2, 1'b0);
		rd(OFS_ACC_BASE, 34'h1);
		wr(OFS_CFG_BASE + 8'h08, 32'(MODE_MARKER) | (32'(MARK_DIR) << CFG_MARK_LSB));
		mpc_pulse_src_i.pulses(2, 1, 100, 0);
		rd(OFS_ACC_BASE, 34'h2);
		wr(OFS_CFG_BASE + 8'h08, 32'(MODE_MARKER));
		mpc_pulse_src_i.pulses(2, 1, 100, 0);
		rd(OFS_ACC_BASE, 34'h0);
		repeat (4) @(posedge core_clk);
		report_and_stop();
	end
endmodule

// [mpc_in_cond.sv]
// input conditioner: two-stage synchroniser, then edges judged once per 1 us tick
// assumes raw pins asynchronous to core_clk and a one-cycle tick pulse
`timescale 1ns/100ps
module mpc_in_cond #(
	parameter int unsigned N = 4
) (
	input  wire logic         core_clk, // core clock
	input  wire logic         sys_rst,  // async reset, high
	input  wire logic         tick,     // 1 us pacing pulse
	input  wire logic [N-1:0] pin_in,   // raw counter pins
	output logic      [N-1:0] lvl,      // synchronised level
	output logic      [N-1:0] rise,     // rising edge seen at this tick
	output logic      [N-1:0] fall      // falling edge seen at this tick
);
	logic [N-1:0] sync1_r;
	logic [N-1:0] sync2_r;
	logic [N-1:0] samp_r;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= pin_in;
			sync2_r <= sync1_r;
		end
	end

	// pulses shorter than a tick can be missed; 100 us spacing keeps that safe
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			samp_r <= '0;
		end else if (tick) begin
			samp_r <= sync2_r;
		end
	end

	assign lvl  = sync2_r;
	assign rise = {N{tick}} & sync2_r & ~samp_r;
	assign fall = {N{tick}} & ~sync2_r & samp_r;
endmodule

// [mpc_pkg.sv]
// shared constants for the multi mode pulse counter: register map, fields, codes, timing
// assumes a 10 MHz core clock; all counting is paced by a 1 us tick
package mpc_pkg;
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned TICK_NS       = 1000;
	localparam int unsigned TICK_CYC      = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned TICKS_PER_SEC = 1000000;
	localparam int unsigned MIN_EDGE_US   = 100;
	localparam int unsigned HW_RST_LAT_US = 100;
	localparam int unsigned NUM_CH        = 4;
	localparam int unsigned ACC_W         = 32;

	// register byte offsets
	localparam logic [7:0] OFS_CFG_BASE = 8'h00;
	localparam logic [7:0] OFS_REV_BASE = 8'h10;
	localparam logic [7:0] OFS_ACC_BASE = 8'h20;
	localparam logic [7:0] OFS_THR_ONE  = 8'h30;
	localparam logic [7:0] OFS_THR_TWO  = 8'h34;
	localparam logic [7:0] OFS_CTRL     = 8'h38;
	localparam logic [7:0] OFS_STAT     = 8'h3C;

	// per-channel config fields
	localparam int unsigned CFG_MODE_LSB = 0;
	localparam int unsigned CFG_EDGE_BIT = 3;
	localparam int unsigned CFG_SUB_LSB  = 4;
	localparam int unsigned CFG_QDIR_BIT = 6;
	localparam int unsigned CFG_MARK_LSB = 7;
	localparam int unsigned CFG_W        = 9;

	// control register fields
	localparam int unsigned CTL_CLR_LSB   = 0;
	localparam int unsigned CTL_SET1_BIT  = 4;
	localparam int unsigned CTL_SET3_BIT  = 5;
	localparam int unsigned CTL_OSEL1_LSB = 6;
	localparam int unsigned CTL_OSEL2_LSB = 8;
	localparam int unsigned CTL_DOUT1_BIT = 10;
	localparam int unsigned CTL_DOUT2_BIT = 11;
	localparam int unsigned CTL_W         = 12;

	// status register fields
	localparam int unsigned STAT_LVL_LSB = 0;
	localparam int unsigned STAT_CMP_LSB = 4;

	// values after reset
	localparam logic [CFG_W-1:0] CFG_RST  = 9'h000;
	localparam logic [31:0]      REV_RST  = 32'h0000_0000;
	localparam logic [31:0]      THR_RST  = 32'h0000_0000;
	localparam logic [CTL_W-1:0] CTRL_RST = 12'h000;

	// channel modes
	localparam logic [2:0] MODE_OFF    = 3'h0;
	localparam logic [2:0] MODE_FREQ   = 3'h1;
	localparam logic [2:0] MODE_TOTAL  = 3'h2;
	localparam logic [2:0] MODE_PULSE  = 3'h3;
	localparam logic [2:0] MODE_QUAD   = 3'h4;
	localparam logic [2:0] MODE_TOTRST = 3'h5;
	localparam logic [2:0] MODE_MARKER = 3'h6;

	// pulse sub-modes
	localparam logic [1:0] SUB_HIGH     = 2'h0;
	localparam logic [1:0] SUB_LOW      = 2'h1;
	localparam logic [1:0] SUB_PER_RISE = 2'h2;
	localparam logic [1:0] SUB_PER_FALL = 2'h3;

	// marker edge choices
	localparam logic [1:0] MARK_RISE = 2'h0;
	localparam logic [1:0] MARK_FALL = 2'h1;
	localparam logic [1:0] MARK_BOTH = 2'h2;
	localparam logic [1:0] MARK_DIR  = 2'h3;

	// special output sources
	localparam logic [1:0] OSEL_DIGITAL = 2'h0;
	localparam logic [1:0] OSEL_PWM     = 2'h1;
	localparam logic [1:0] OSEL_CMP     = 2'h2;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [mpc_pulse_src.sv]
// pulse source and quadrature encoder driving the counter pins
// assumes times in microseconds; pins idle low
`timescale 1ns/100ps
module mpc_pulse_src (
	output logic [3:0] pin // counter pins, positive logic
);
	int ph;
	initial begin
		pin = 4'h0;
		ph = 0;
	end
	// 1 ns offset keeps edges off the clock edge, so sampling never races
	task automatic pulses(input int ch, input int n, input int hi_us, input int lo_us);
		#1;
		repeat (n) begin
			pin[ch] = 1'b1;
			#(hi_us * 1us);
			pin[ch] = 1'b0;
			#(lo_us * 1us);
		end
	endtask
	// gray order 00,01,11,10 on {b,a}: phase a leads
	task automatic steps(input int n, input bit back);
		logic [1:0] g [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
		#1;
		repeat (n) begin
			ph = back ? (ph + 3) % 4 : (ph + 1) % 4;
			pin[1:0] = g[ph];
			#100us;
		end
	endtask
endmodule
